// >>> hw/synchrocheck_release.sv
// Notes on behaviour
// - Channels 0-2 are bus voltages; channel 3 is line, compared with selected bus phase.
// - Slip frequency is the absolute difference of bus and line frequency.
// - Synchronous indication only while magnitude, slip and angle are all within limits.
// - Generator mode advances release by closing time so contacts meet at zero angle.
// - Generator mode angle check uses the predicted angle after the closing time.
// - Grid-to-grid mode checks the same three conditions without closing-time compensation.
// - A control bit chooses grid-to-grid or generator-to-grid checking.
// - When enabled, manual, automatic or both closing requests are supervised as configured.
// - Each enabled dead/live override permits release regardless of the three checks.
// - An external bypass input permits release without any synchronism check.
// - Transformer mode corrects amplitude and angle mismatch before checking.
// - Amplitude correction uses the configured line-to-bus voltage ratio.
// - Angle correction adds the configured line-minus-bus angle offset.
//
// Local design decisions: register access over Avalon-MM and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "sync_consts.svh"

module synchrocheck_release (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Avalon-MM slave.
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Measurement channels.
    input wire sync_pkg::chan_t [2:0] busChan,
    input wire sync_pkg::chan_t lineChan,
    input wire logic measValid,
    // Closing requests and bypass.
    input wire logic manualCloseReq,
    input wire logic autoCloseReq,
    input wire logic bypassSync,
    // Results.
    output logic syncRelease,
    output logic manualCloseOut,
    output logic autoCloseOut,
    output logic irq
);

    // The whole state of the block.
    typedef struct packed {
        sync_pkg::bus_state_t busState;
        logic waitrequest;
        logic [31:0] readdata;
        sync_pkg::ctrl_t ctrl;
        sync_pkg::word_t magLimit;
        sync_pkg::word_t slipLimit;
        sync_pkg::word_t angleLimit;
        sync_pkg::word_t breakerTime;
        sync_pkg::word_t voltRatio;
        sync_pkg::word_t angleCorr;
        sync_pkg::word_t deadLevel;
        sync_pkg::word_t liveLevel;
        logic [`SC_IRQ_W-1:0] irqStatus;
        logic [`SC_IRQ_W-1:0] irqMask;
        sync_pkg::status_t status;
        sync_pkg::word_t slipMeas;
        logic syncRelease;
        logic manualCloseOut;
        logic autoCloseOut;
        logic blockedPrev;
        logic irq;
    } state_t;

    state_t st;
    state_t next_st;

    // Signals of the evaluation path.
    sync_pkg::chan_t busSel;
    logic [31:0] ratioProduct;
    sync_pkg::word_t busMagComp;
    sync_pkg::word_t busAngComp;
    logic [31:0] slipTimeProduct;
    logic [47:0] advanceWide;
    sync_pkg::word_t advance;
    sync_pkg::word_t busAngPredicted;
    sync_pkg::word_t busAngChecked;
    sync_pkg::word_t magDelta;
    sync_pkg::word_t slipDelta;
    sync_pkg::word_t angleDelta;
    logic magOk;
    logic slipOk;
    logic angleOk;

    // A phase select of 3 is not a phase; it falls back to the first bus channel.
    always_comb
    begin
        unique case (st.ctrl.phaseSelect)
            2'h1: busSel = busChan[1];
            2'h2: busSel = busChan[2];
            default: busSel = busChan[0];
        endcase
    end

    // Transformer correction of the bus magnitude, saturated at full scale.
    assign ratioProduct = busSel.mag * st.voltRatio;
    always_comb
    begin
        if (!st.ctrl.transformerMode)
        begin
            busMagComp = busSel.mag;
        end
        else if (ratioProduct[31:`SC_RATIO_FRAC + 16] != '0)
        begin
            busMagComp = 16'hFFFF;
        end
        else
        begin
            busMagComp = ratioProduct[`SC_RATIO_FRAC + 15:`SC_RATIO_FRAC];
        end
    end

    // The bus angle is shifted by the expected line-minus-bus offset, modulo one turn.
    assign busAngComp = st.ctrl.transformerMode ? 16'(busSel.ang + st.angleCorr) : busSel.ang;

    // Angle travelled during the breaker closing time at the present slip.
    // The product is wide so long closing times at high slip saturate instead of wrapping.
    assign slipTimeProduct = slipDelta * st.breakerTime;
    assign advanceWide = slipTimeProduct * `SC_ADV_SCALE;
    assign advance = (advanceWide[47:`SC_ADV_SHIFT + 16] != '0) ? 16'hFFFF
                     : advanceWide[`SC_ADV_SHIFT + 15:`SC_ADV_SHIFT];

    // A faster bus runs ahead of the line, so its angle moves forward during closing.
    always_comb
    begin
        if (busSel.freq >= lineChan.freq)
        begin
            busAngPredicted = 16'(busAngComp + advance);
        end
        else
        begin
            busAngPredicted = 16'(busAngComp - advance);
        end
    end

    // Generator mode judges the angle at the moment the contacts will touch.
    assign busAngChecked = st.ctrl.genToGridMode ? busAngPredicted : busAngComp;

    // Magnitude difference check.
    delta_limit #(
        .WRAP(1'b0)
    ) magCheck (
        .first(busMagComp),
        .second(lineChan.mag),
        .limit(st.magLimit),
        .delta(magDelta),
        .inLimit(magOk)
    );

    // Slip frequency check.
    delta_limit #(
        .WRAP(1'b0)
    ) slipCheck (
        .first(busSel.freq),
        .second(lineChan.freq),
        .limit(st.slipLimit),
        .delta(slipDelta),
        .inLimit(slipOk)
    );

    // Phase angle check, modulo one turn.
    delta_limit #(
        .WRAP(1'b1)
    ) angleCheck (
        .first(busAngChecked),
        .second(lineChan.ang),
        .limit(st.angleLimit),
        .delta(angleDelta),
        .inLimit(angleOk)
    );

    // Register read multiplexer; unmapped offsets read as zero.
    function automatic logic [31:0] read_mux(input state_t s, input logic [5:0] addr);
        logic [31:0] value;
        value = 32'h00000000;
        unique case (addr)
            `SC_ADDR_CTRL: value = 32'(s.ctrl);
            `SC_ADDR_MAG_LIMIT: value = 32'(s.magLimit);
            `SC_ADDR_SLIP_LIMIT: value = 32'(s.slipLimit);
            `SC_ADDR_ANGLE_LIMIT: value = 32'(s.angleLimit);
            `SC_ADDR_BREAKER_TIME: value = 32'(s.breakerTime);
            `SC_ADDR_VOLT_RATIO: value = 32'(s.voltRatio);
            `SC_ADDR_ANGLE_CORR: value = 32'(s.angleCorr);
            `SC_ADDR_DEAD_LEVEL: value = 32'(s.deadLevel);
            `SC_ADDR_LIVE_LEVEL: value = 32'(s.liveLevel);
            `SC_ADDR_STATUS: value = 32'(s.status);
            `SC_ADDR_IRQ_STATUS: value = 32'(s.irqStatus);
            `SC_ADDR_IRQ_MASK: value = 32'(s.irqMask);
            `SC_ADDR_SLIP_MEAS: value = 32'(s.slipMeas);
            default: value = 32'h00000000;
        endcase
        return value;
    endfunction : read_mux

    // Next state: bus slave, release decision, close supervision and interrupts.
    always_comb
    begin
        logic [`SC_IRQ_W-1:0] irqClear;
        logic [`SC_IRQ_W-1:0] irqEvents;
        logic busLive;
        logic busDead;
        logic lineLive;
        logic lineDead;
        logic overrideActive;
        logic syncOk;
        logic releaseNow;
        logic blockedNow;
        next_st = st;
        irqClear = '0;
        irqEvents = '0;

        // Dead and live judgements use the raw selected bus and the line magnitudes.
        busLive = (busSel.mag >= st.liveLevel);
        busDead = (busSel.mag < st.deadLevel);
        lineLive = (lineChan.mag >= st.liveLevel);
        lineDead = (lineChan.mag < st.deadLevel);
        overrideActive = (st.ctrl.liveBusDeadLineEn && busLive && lineDead)
                         || (st.ctrl.deadBusLiveLineEn && busDead && lineLive)
                         || (st.ctrl.deadBusDeadLineEn && busDead && lineDead);

        // Release is recomputed every cycle, so without bypass or override it falls the cycle after any check fails.
        syncOk = measValid && magOk && slipOk && angleOk;
        releaseNow = st.ctrl.enable && (bypassSync || overrideActive || syncOk);
        blockedNow = st.ctrl.enable && !releaseNow
                     && ((manualCloseReq && st.ctrl.superviseManual)
                         || (autoCloseReq && st.ctrl.superviseAuto));

        // Every access is answered after one wait cycle; a write lands on the edge
        // where waitrequest is seen low, matching the Avalon completion rule.
        unique case (st.busState)
            sync_pkg::BUS_IDLE:
            begin
                if (read || write)
                begin
                    next_st.busState = sync_pkg::BUS_ACK;
                    next_st.waitrequest = 1'b0;
                    next_st.readdata = read ? read_mux(st, address) : st.readdata;
                end
            end
            sync_pkg::BUS_ACK:
            begin
                next_st.busState = sync_pkg::BUS_IDLE;
                next_st.waitrequest = 1'b1;
                if (write)
                begin
                    unique case (address)
                        `SC_ADDR_CTRL: next_st.ctrl = sync_pkg::ctrl_t'(writedata[`SC_CTRL_W-1:0]);
                        `SC_ADDR_MAG_LIMIT: next_st.magLimit = writedata[15:0];
                        `SC_ADDR_SLIP_LIMIT: next_st.slipLimit = writedata[15:0];
                        `SC_ADDR_ANGLE_LIMIT: next_st.angleLimit = writedata[15:0];
                        `SC_ADDR_BREAKER_TIME: next_st.breakerTime = writedata[15:0];
                        `SC_ADDR_VOLT_RATIO: next_st.voltRatio = writedata[15:0];
                        `SC_ADDR_ANGLE_CORR: next_st.angleCorr = writedata[15:0];
                        `SC_ADDR_DEAD_LEVEL: next_st.deadLevel = writedata[15:0];
                        `SC_ADDR_LIVE_LEVEL: next_st.liveLevel = writedata[15:0];
                        `SC_ADDR_IRQ_STATUS: irqClear = writedata[`SC_IRQ_W-1:0];
                        `SC_ADDR_IRQ_MASK: next_st.irqMask = writedata[`SC_IRQ_W-1:0];
                        default: irqClear = '0;
                    endcase
                end
            end
        endcase

        // A supervised request passes only with release; an unsupervised one passes freely.
        next_st.syncRelease = releaseNow;
        next_st.manualCloseOut = manualCloseReq
                                 && (!(st.ctrl.enable && st.ctrl.superviseManual) || releaseNow);
        next_st.autoCloseOut = autoCloseReq
                               && (!(st.ctrl.enable && st.ctrl.superviseAuto) || releaseNow);
        next_st.blockedPrev = blockedNow;

        // Live status for software.
        next_st.status.granted = releaseNow;
        next_st.status.magOk = magOk;
        next_st.status.slipOk = slipOk;
        next_st.status.angleOk = angleOk;
        next_st.status.overrideActive = overrideActive;
        next_st.status.bypassActive = bypassSync;
        next_st.status.measValid = measValid;
        next_st.slipMeas = slipDelta;

        // Sticky events; a new event wins over a clear in the same cycle.
        irqEvents[`SC_IRQ_RELEASE_ON] = releaseNow && !st.syncRelease;
        irqEvents[`SC_IRQ_RELEASE_OFF] = !releaseNow && st.syncRelease;
        irqEvents[`SC_IRQ_CLOSE_BLOCKED] = blockedNow && !st.blockedPrev;
        next_st.irqStatus = (st.irqStatus & ~irqClear) | irqEvents;
        next_st.irq = |(next_st.irqStatus & next_st.irqMask);
    end

    // State register with synchronous active-low reset.
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            st <= '{
                busState: sync_pkg::BUS_IDLE,
                waitrequest: 1'b1,
                readdata: 32'h00000000,
                ctrl: sync_pkg::ctrl_t'(`SC_RST_CTRL),
                magLimit: `SC_RST_LIMIT,
                slipLimit: `SC_RST_LIMIT,
                angleLimit: `SC_RST_LIMIT,
                breakerTime: `SC_RST_BREAKER_TIME,
                voltRatio: `SC_RST_VOLT_RATIO,
                angleCorr: `SC_RST_ANGLE_CORR,
                deadLevel: `SC_RST_DEAD_LEVEL,
                liveLevel: `SC_RST_LIVE_LEVEL,
                irqStatus: `SC_RST_IRQ,
                irqMask: `SC_RST_IRQ,
                status: '0,
                slipMeas: 16'h0000,
                syncRelease: 1'b0,
                manualCloseOut: 1'b0,
                autoCloseOut: 1'b0,
                blockedPrev: 1'b0,
                irq: 1'b0
            };
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs come straight from the state flops.
    assign readdata = st.readdata;
    assign waitrequest = st.waitrequest;
    assign syncRelease = st.syncRelease;
    assign manualCloseOut = st.manualCloseOut;
    assign autoCloseOut = st.autoCloseOut;
    assign irq = st.irq;

endmodule : synchrocheck_release

`default_nettype wire

// >>> hw/sync_consts.svh
`ifndef SYNC_CONSTS_SVH
`define SYNC_CONSTS_SVH

// Register byte offsets on the Avalon-MM slave, one aligned word each.
`define SC_ADDR_CTRL 6'h00
`define SC_ADDR_MAG_LIMIT 6'h04
`define SC_ADDR_SLIP_LIMIT 6'h08
`define SC_ADDR_ANGLE_LIMIT 6'h0C
`define SC_ADDR_BREAKER_TIME 6'h10
`define SC_ADDR_VOLT_RATIO 6'h14
`define SC_ADDR_ANGLE_CORR 6'h18
`define SC_ADDR_DEAD_LEVEL 6'h1C
`define SC_ADDR_LIVE_LEVEL 6'h20
`define SC_ADDR_STATUS 6'h24
`define SC_ADDR_IRQ_STATUS 6'h28
`define SC_ADDR_IRQ_MASK 6'h2C
`define SC_ADDR_SLIP_MEAS 6'h30

// Field widths of the packed control, status and interrupt words.
`define SC_CTRL_W 10
`define SC_STATUS_W 7
`define SC_IRQ_W 3

// Interrupt bit positions.
`define SC_IRQ_RELEASE_ON 0
`define SC_IRQ_RELEASE_OFF 1
`define SC_IRQ_CLOSE_BLOCKED 2

// Reset values.
`define SC_RST_CTRL 10'h000
`define SC_RST_LIMIT 16'h0000
`define SC_RST_BREAKER_TIME 16'h0000
`define SC_RST_VOLT_RATIO 16'h1000
`define SC_RST_ANGLE_CORR 16'h0000
`define SC_RST_DEAD_LEVEL 16'h0000
`define SC_RST_LIVE_LEVEL 16'hFFFF
`define SC_RST_IRQ 3'h0

// Voltage ratio is unsigned fixed point with this many fraction bits.
`define SC_RATIO_FRAC 12

// Slip in mHz times closing time in ms gives micro-turns; times 2^32/1e6 and
// shifted right by 16 this becomes angle units of 2^-16 turn.
`define SC_ADV_SCALE 16'h10C7
`define SC_ADV_SHIFT 16

`endif

// >>> hw/sync_pkg.sv
`default_nettype none

package sync_pkg;

    // Common data word of all measured and configured quantities.
    typedef logic [15:0] word_t;

    // One voltage channel: magnitude, phasor angle (full turn = 2^16) and frequency in mHz.
    typedef struct packed {
        word_t mag;
        word_t ang;
        word_t freq;
    } chan_t;

    // Control word, bit 0 at the bottom.
    typedef struct packed {
        logic transformerMode;
        logic deadBusDeadLineEn;
        logic deadBusLiveLineEn;
        logic liveBusDeadLineEn;
        logic superviseAuto;
        logic superviseManual;
        logic [1:0] phaseSelect;
        logic genToGridMode;
        logic enable;
    } ctrl_t;

    // Live status word, bit 0 at the bottom.
    typedef struct packed {
        logic measValid;
        logic bypassActive;
        logic overrideActive;
        logic angleOk;
        logic slipOk;
        logic magOk;
        logic granted;
    } status_t;

    typedef enum logic {
        BUS_IDLE,
        BUS_ACK
    } bus_state_t;

endpackage : sync_pkg

`default_nettype wire

// >>> hw/delta_limit.sv
`timescale 1ns/10ps
`default_nettype none

// Absolute difference of two words and its comparison with a limit.
// With WRAP set the difference is taken modulo a full turn, for angles.
module delta_limit #(
    parameter bit WRAP = 1'b0
) (
    // Operands.
    input wire sync_pkg::word_t first,
    input wire sync_pkg::word_t second,
    input wire sync_pkg::word_t limit,
    // Result.
    output sync_pkg::word_t delta,
    output logic inLimit
);

    logic [16:0] wide;
    logic negative;

    // A wrapped angle difference lies within half a turn, so bit 15 is its sign.
    always_comb
    begin
        wide = {1'b0, first} - {1'b0, second};
        negative = WRAP ? wide[15] : wide[16];
        delta = negative ? 16'(-wide[15:0]) : wide[15:0];
        inLimit = (delta <= limit);
    end

endmodule : delta_limit

`default_nettype wire

// >>> test/sync_props.sv
`timescale 1ns/10ps
`default_nettype none

// Watches the bus handshake and the gated outputs of the release block.
module sync_props (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Avalon-MM slave.
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // Requests and results.
    input wire logic manualCloseReq,
    input wire logic autoCloseReq,
    input wire logic syncRelease,
    input wire logic manualCloseOut,
    input wire logic autoCloseOut,
    input wire logic irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // The slave answers every taken request after one wait cycle, for one cycle only.
    a_ack_after_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("request not answered after one wait cycle");
    a_ack_single_cycle: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_ack_has_cause: assert property (!waitrequest |-> $past(waitrequest) && $past(read || write))
        else $error("answer without a pending request");
    // Registers are at most 16 bits wide and unmapped offsets read zero.
    a_upper_bits_zero: assert property (!waitrequest && read |-> readdata[31:16] == 16'h0000)
        else $error("upper read data bits not zero");
    a_unmapped_reads_zero: assert property (!waitrequest && read && address >= 6'h34 |-> readdata == 32'h0)
        else $error("unmapped offset read not zero");
    // Reset must be checked while reset is asserted, so it overrides the default disable.
    property resetIdle;
        disable iff (1'b0) !rst_b |=> waitrequest && !syncRelease && !irq && readdata == 32'h0;
    endproperty
    a_reset_outputs_idle: assert property (resetIdle)
        else $error("outputs not idle after reset");
    // A gated close output needs its request one cycle earlier, and a release lets the manual one through.
    a_manual_gate_cause: assert property (manualCloseOut |-> $past(manualCloseReq))
        else $error("manual close output without request");
    a_manual_pass_release: assert property ($past(manualCloseReq) && syncRelease |-> manualCloseOut)
        else $error("manual request blocked during release");
    a_auto_gate_cause: assert property (autoCloseOut |-> $past(autoCloseReq))
        else $error("automatic close output without request");

    c_release_rise: cover property ($rose(syncRelease));
    c_irq_rise: cover property ($rose(irq));
    c_close_blocked: cover property (manualCloseReq ##1 !manualCloseOut);
endmodule : sync_props

bind synchrocheck_release sync_props sync_props_u (.clk(clk), .rst_b(rst_b), .address(address),
    .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest),
    .manualCloseReq(manualCloseReq), .autoCloseReq(autoCloseReq), .syncRelease(syncRelease),
    .manualCloseOut(manualCloseOut), .autoCloseOut(autoCloseOut), .irq(irq));

`default_nettype wire

// >>> test/meas_source.sv
`timescale 1ns/10ps
`default_nettype none

// Behavioural measurement front end with one register stage.
module meas_source (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Wanted values.
    input wire sync_pkg::chan_t busSet,
    input wire sync_pkg::chan_t lineSet,
    input wire logic [1:0] phaseSel,
    input wire logic validSet,
    // Channels.
    output var sync_pkg::chan_t [2:0] busChan,
    output var sync_pkg::chan_t lineChan,
    output logic measValid
);
    // Unselected phases carry the inverse, so a wrong phase choice cannot pass by luck.
    always_ff @(posedge clk)
    begin
        for (int i = 0; i < 3; i++)
        begin
            busChan[i] <= (i == int'(phaseSel) || (phaseSel == 2'h3 && i == 0)) ? busSet : ~busSet;
        end
        lineChan <= lineSet;
        measValid <= rst_b && validSet;
    end
endmodule : meas_source

`default_nettype wire

// >>> test/synchrocheck_release_tb.sv
`timescale 1ns/10ps
`default_nettype none

module synchrocheck_release_tb;
    logic clk, rst_b, read, write, waitrequest, measValid, validSet;
    logic manualCloseReq, autoCloseReq, bypassSync, syncRelease, manualCloseOut, autoCloseOut, irq;
    logic [5:0] address;
    logic [31:0] writedata, readdata, rd;
    logic [1:0] phaseSel;
    sync_pkg::chan_t [2:0] busChan;
    sync_pkg::chan_t lineChan, busSet, lineSet;
    int failCount, comparisons;
    logic [5:0] rstAddr [13] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14, 6'h18, 6'h1C, 6'h20, 6'h28,
        6'h2C, 6'h30, 6'h34};
    // Reset selects phase 0, fed the inverse, so the slip register reads 0x86A1.
    logic [15:0] rstVal [13] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h1000, 16'h0000,
        16'h0000, 16'hFFFF, 16'h0000, 16'h0000, 16'h86A1, 16'h0000};
    logic [15:0] ovBus [3] = '{16'h0300, 16'h0010, 16'h0010};
    logic [15:0] ovLine [3] = '{16'h0010, 16'h0300, 16'h0010};
    logic [15:0] ovBit [3] = '{16'h0040, 16'h0080, 16'h0100};

    meas_source src_u (.clk(clk), .rst_b(rst_b), .busSet(busSet), .lineSet(lineSet), .phaseSel(phaseSel),
        .validSet(validSet), .busChan(busChan), .lineChan(lineChan), .measValid(measValid));
    synchrocheck_release dut_u (.clk(clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .busChan(busChan),
        .lineChan(lineChan), .measValid(measValid), .manualCloseReq(manualCloseReq),
        .autoCloseReq(autoCloseReq), .bypassSync(bypassSync), .syncRelease(syncRelease),
        .manualCloseOut(manualCloseOut), .autoCloseOut(autoCloseOut), .irq(irq));

    // One Avalon access; the request stands until the edge that sees waitrequest low.
    task automatic busAccess(input logic wr, input logic [5:0] a, input logic [15:0] d);
        @(posedge clk);
        address <= a;
        writedata <= {16'h0000, d};
        write <= wr;
        read <= !wr;
        do
        begin
            @(posedge clk);
        end
        while (waitrequest !== 1'b0);
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask : busAccess

    task automatic chkWord(input string name, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            failCount++;
            $display("unexpected %s: expected %h, seen %h", name, e, g);
        end
    endtask : chkWord

    task automatic chkBit(input string name, input logic e, input logic g);
        chkWord(name, {31'h0, e}, {31'h0, g});
    endtask : chkBit

    task automatic regChk(input logic [5:0] a, input logic [15:0] e);
        busAccess(1'b0, a, 16'h0000);
        chkWord($sformatf("register %h", a), {16'h0000, e}, rd);
    endtask : regChk

    // Bus phasor first, then line phasor, each as magnitude, angle, frequency.
    task automatic setMeas(input logic [15:0] bm, ba, bf, lm, la, lf);
        busSet <= {bm, ba, bf};
        lineSet <= {lm, la, lf};
    endtask : setMeas

    // Source stage plus the one-cycle evaluation latency, with a spare cycle.
    task automatic expRel(input logic e);
        repeat (3) @(posedge clk);
        #1;
        chkBit("syncRelease", e, syncRelease);
    endtask : expRel

    task automatic endTest(input string name);
        $display("test %s finished", name);
    endtask : endTest

    task automatic testDone();
        $display("comparisons %0d, mismatches %0d", comparisons, failCount);
        if (failCount == 0 && comparisons > 0)
        begin
            $display("SIMULATION PASSED");
        end
        else
        begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : testDone

    // Free-running bench clock.
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // The whole sequence needs well under a thousand cycles, so this only cuts a hang.
    initial
    begin
        #(5000 * 50);
        failCount++;
        testDone();
    end

    initial
    begin
        rst_b = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 6'h00;
        writedata = 32'h0;
        manualCloseReq = 1'b0;
        autoCloseReq = 1'b0;
        bypassSync = 1'b0;
        phaseSel = 2'h1;
        validSet = 1'b1;
        busSet = {16'h03E8, 16'h0000, 16'hC350};
        lineSet = busSet;
        failCount = 0;
        comparisons = 0;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        // Writes to unmapped and read-only places must leave no trace.
        busAccess(1'b1, 6'h34, 16'hFFFF);
        busAccess(1'b1, 6'h30, 16'h1234);
        for (int i = 0; i < 13; i++)
        begin
            regChk(rstAddr[i], rstVal[i]);
        end
        endTest("reset values");
        // Grid-to-grid with every quantity exactly on its inclusive limit, then one step over.
        busAccess(1'b1, 6'h04, 16'h0100);
        busAccess(1'b1, 6'h08, 16'h0064);
        busAccess(1'b1, 6'h0C, 16'h0200);
        busAccess(1'b1, 6'h00, 16'h0005);
        setMeas(16'h03E8, 16'h0000, 16'hC350, 16'h04E8, 16'h0200, 16'hC3B4);
        expRel(1'b1);
        regChk(6'h30, 16'h0064);
        for (int i = 0; i < 3; i++)
        begin
            setMeas(16'h03E8, 16'h0000, 16'hC350, 16'h04E8 + (i == 0), 16'h0200 + (i == 1), 16'hC3B4 + (i == 2));
            expRel(1'b0);
        end
        setMeas(16'h03E8, 16'hFE00, 16'hC3B4, 16'h04E8, 16'h0000, 16'hC350);
        expRel(1'b1);
        regChk(6'h30, 16'h0064);
        endTest("grid to grid");
        // A 100 ms closing time at 100 mHz slip leads the bus angle by 0x28F.
        busAccess(1'b1, 6'h0C, 16'h0010);
        busAccess(1'b1, 6'h10, 16'h0064);
        setMeas(16'h03E8, 16'h0000, 16'hC3B4, 16'h03E8, 16'h028F, 16'hC350);
        expRel(1'b0);
        busAccess(1'b1, 6'h00, 16'h0007);
        expRel(1'b1);
        endTest("generator to grid");
        // Half ratio and a quarter turn, i.e. vector group 3 with the primary on the bus side.
        busAccess(1'b1, 6'h14, 16'h0800);
        busAccess(1'b1, 6'h18, 16'h4000);
        setMeas(16'h07D0, 16'h0000, 16'hC350, 16'h03E8, 16'h4000, 16'hC350);
        expRel(1'b0);
        busAccess(1'b1, 6'h00, 16'h0205);
        expRel(1'b1);
        busAccess(1'b1, 6'h18, 16'hC000);
        setMeas(16'h07D0, 16'h0000, 16'hC350, 16'h03E8, 16'hC000, 16'hC350);
        expRel(1'b1);
        endTest("transformer");
        // Each override lets a failing angle through only while its own enable is set.
        busAccess(1'b1, 6'h1C, 16'h0050);
        busAccess(1'b1, 6'h20, 16'h0200);
        for (int i = 0; i < 3; i++)
        begin
            setMeas(ovBus[i], 16'h0000, 16'hC350, ovLine[i], 16'h8000, 16'hC350);
            busAccess(1'b1, 6'h00, 16'h0005);
            expRel(1'b0);
            busAccess(1'b1, 6'h00, 16'h0005 | ovBit[i]);
            expRel(1'b1);
        end
        endTest("overrides");
        bypassSync <= 1'b1;
        busAccess(1'b1, 6'h00, 16'h0005);
        expRel(1'b1);
        busAccess(1'b1, 6'h00, 16'h0000);
        expRel(1'b0);
        bypassSync <= 1'b0;
        endTest("bypass");
        // Manual requests supervised, automatic ones not; the blocked close raises an event.
        busAccess(1'b1, 6'h00, 16'h0015);
        busAccess(1'b1, 6'h28, 16'h0007);
        manualCloseReq <= 1'b1;
        autoCloseReq <= 1'b1;
        expRel(1'b0);
        chkBit("manualCloseOut", 1'b0, manualCloseOut);
        chkBit("autoCloseOut", 1'b1, autoCloseOut);
        regChk(6'h28, 16'h0004);
        chkBit("irq", 1'b0, irq);
        busAccess(1'b1, 6'h2C, 16'h0004);
        expRel(1'b0);
        chkBit("irq", 1'b1, irq);
        busAccess(1'b1, 6'h28, 16'h0004);
        expRel(1'b0);
        chkBit("irq", 1'b0, irq);
        setMeas(16'h03E8, 16'h0000, 16'hC350, 16'h03E8, 16'h0000, 16'hC350);
        expRel(1'b1);
        chkBit("manualCloseOut", 1'b1, manualCloseOut);
        regChk(6'h28, 16'h0001);
        chkBit("irq", 1'b0, irq);
        endTest("supervision and interrupt");
        testDone();
    end
endmodule : synchrocheck_release_tb

`default_nettype wire
